// ==== rtl/rcb_csr_bank.sv ====
// Capability and logical-layer control register bank of a serial
// packet endpoint. Remote maintenance accesses and local bus masters
// share one register port; the block answers every request one cycle
// later with a registered acknowledge, and reads also with read data.
// Assumes requests come from logic on core_clk and that only one
// request is presented per cycle.
`timescale 1ns/1ps
module rcb_csr_bank #(
  parameter logic LARGE_SYS = rcb_pkg::RST_LARGE_SYS,
  parameter logic [2:0] EXT_ADDR_SUPPORT = rcb_pkg::RST_EXT_ADDR_SUPPORT,
  parameter logic [7:0] PORT_TOTAL = rcb_pkg::RST_PORT_TOTAL,
  parameter logic [15:0] MAX_UNIT_SIZE = rcb_pkg::RST_MAX_UNIT_SIZE,
  parameter logic [15:0] SEG_CONTEXT_COUNT = rcb_pkg::RST_SEG_CONTEXT_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_from_link,
  input wire logic [7:0] reg_link_port,
  output logic reg_ack,
  output logic reg_err,
  output logic [31:0] reg_rdata,
  output logic large_id_mode,
  output logic [2:0] addr_width_sel,
  output logic [3:0] traffic_mgmt_select,
  output logic traffic_mgmt_unsupported,
  output logic [8:0] seg_payload_bytes
);
  import rcb_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The element must always handle 34-bit addresses both ways
  if (EXT_ADDR_SUPPORT[0] != 1'b1)
  begin : g_bad_addr_support
    $error("address support must include 34-bit");
  end
  // Only the four documented support codes exist
  if (!(EXT_ADDR_SUPPORT inside {3'h1, 3'h3, 3'h5, 3'h7}))
  begin : g_bad_addr_code
    $error("address support code is not defined");
  end
  // A port total of zero is a reserved code
  if (PORT_TOTAL == 8'h00)
  begin : g_bad_port_total
    $error("port total must be 1 to 255");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] feature_word; // Fixed feature flags
  logic [31:0] source_word; // Fixed source capabilities
  logic [31:0] dest_word; // Fixed destination capabilities
  logic [31:0] stream_info_word; // Fixed streaming limits
  logic [31:0] port_word; // Port information, arrival dependent
  logic [31:0] stream_ctl_word; // Streaming control read image
  logic [31:0] addr_ctl_word; // Address control read image
  logic hit_feature; // Address decodes
  logic hit_port;
  logic hit_source;
  logic hit_dest;
  logic hit_info;
  logic hit_stream_ctl;
  logic hit_addr_ctl;
  logic hit_any; // Any mapped register
  logic wr_stream_ctl; // Write strobes into writable fields
  logic wr_addr_ctl;
  logic payload_legal; // Proposed payload code is allowed
  logic addr_sel_legal; // Proposed address select is allowed
  logic wr_refused; // A write to a writable register was rejected
  logic [7:0] seg_payload_size_ff; // Held payload size code
  logic [3:0] traffic_mgmt_select_ff; // Held traffic-management select
  logic [2:0] addr_width_sel_ff; // Held address width select
  logic nxt_ack; // Answer strobe next value
  logic nxt_err; // Error strobe next value
  logic [31:0] nxt_rdata; // Read data next value
  logic reg_ack_ff; // Registered answer
  logic reg_err_ff;
  logic [31:0] reg_rdata_ff;

  // ----------------------------------------------------------------
  // Fixed capability words
  // ----------------------------------------------------------------
  rcb_cap_words #(
    .LARGE_SYS(LARGE_SYS),
    .EXT_ADDR_SUPPORT(EXT_ADDR_SUPPORT),
    .PORT_TOTAL(PORT_TOTAL),
    .MAX_UNIT_SIZE(MAX_UNIT_SIZE),
    .SEG_CONTEXT_COUNT(SEG_CONTEXT_COUNT)
  ) u_cap_words (
    .feature_word(feature_word),
    .source_word(source_word),
    .dest_word(dest_word),
    .stream_info_word(stream_info_word)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Full byte compare, so a misaligned offset is treated as unmapped
  always_comb
  begin
    hit_feature = (reg_addr == OFS_ELEMENT_FEATURE_FLAGS);
    hit_port = (reg_addr == OFS_SWITCH_PORT_INFO);
    hit_source = (reg_addr == OFS_SOURCE_OPERATION_CAPS);
    hit_dest = (reg_addr == OFS_DESTINATION_OPERATION_CAPS);
    hit_info = (reg_addr == OFS_STREAMING_CAPABILITY_INFO);
    hit_stream_ctl = (reg_addr == OFS_STREAMING_LOGICAL_CONTROL);
    hit_addr_ctl = (reg_addr == OFS_LOGICAL_LAYER_ADDRESS_CONTROL);
    hit_any = hit_feature | hit_port | hit_source | hit_dest | hit_info |
              hit_stream_ctl | hit_addr_ctl;
  end

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  // Only the two control registers take writes; writes to the fixed
  // words simply fall through and leave nothing behind
  always_comb
  begin
    wr_stream_ctl = reg_req && reg_wr && hit_stream_ctl;
    wr_addr_ctl = reg_req && reg_wr && hit_addr_ctl;
    // Reserved payload codes would break segmentation; keep the old one
    payload_legal = seg_payload_ok(reg_wdata[CTL_SEG_PAYLOAD_LSB +: 8]);
    // Reserved or unsupported address widths are refused the same way
    addr_sel_legal = addr_sel_ok(reg_wdata[CTL_ADDR_SEL_LSB +: 3],
                                 EXT_ADDR_SUPPORT);
    wr_refused = (wr_stream_ctl && !payload_legal) ||
                 (wr_addr_ctl && !addr_sel_legal);
  end

  // ----------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------
  // Payload size and select share one write; both are refused together
  // so a rejected word leaves the whole register untouched
  rcb_wfield #(
    .WIDTH(8),
    .RESET_VAL(RST_SEG_PAYLOAD_SIZE)
  ) u_seg_payload (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_stream_ctl),
    .wr_legal(payload_legal),
    .wr_val(reg_wdata[CTL_SEG_PAYLOAD_LSB +: 8]),
    .field_ff(seg_payload_size_ff)
  );

  // Traffic-management select, reset to disabled
  rcb_wfield #(
    .WIDTH(4),
    .RESET_VAL(RST_TM_SELECT)
  ) u_tm_select (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_stream_ctl),
    .wr_legal(payload_legal),
    .wr_val(reg_wdata[CTL_TM_SELECT_LSB +: 4]),
    .field_ff(traffic_mgmt_select_ff)
  );

  // Address width select, reset to 34-bit
  rcb_wfield #(
    .WIDTH(3),
    .RESET_VAL(RST_ADDR_SEL)
  ) u_addr_sel (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_addr_ctl),
    .wr_legal(addr_sel_legal),
    .wr_val(reg_wdata[CTL_ADDR_SEL_LSB +: 3]),
    .field_ff(addr_width_sel_ff)
  );

  // ----------------------------------------------------------------
  // Read images
  // ----------------------------------------------------------------
  always_comb
  begin
    // Port total is the single-lane count even in wide-lane modes
    port_word = 32'h0000_0000;
    port_word[PORT_TOTAL_LSB +: 8] = PORT_TOTAL;
    // Arrival port for link reads, zero for local masters
    if (reg_from_link)
    begin
      port_word[PORT_NUM_LSB +: 8] = reg_link_port;
    end
    else
    begin
      port_word[PORT_NUM_LSB +: 8] = 8'h00;
    end
    // Type caps are hard zero; bits 23:8 are reserved zero
    stream_ctl_word = 32'h0000_0000;
    stream_ctl_word[CTL_TM_TYPES_LSB +: 4] = RST_TM_TYPE_CAPS;
    stream_ctl_word[CTL_TM_SELECT_LSB +: 4] = traffic_mgmt_select_ff;
    stream_ctl_word[CTL_SEG_PAYLOAD_LSB +: 8] = seg_payload_size_ff;
    // Upper bits are never stored, so they always read zero
    addr_ctl_word = 32'h0000_0000;
    addr_ctl_word[CTL_ADDR_SEL_LSB +: 3] = addr_width_sel_ff;
  end

  // ----------------------------------------------------------------
  // Answer: next values
  // ----------------------------------------------------------------
  // Every request gets one ack; unmapped offsets and refused writes
  // also raise the error strobe. Reads of unmapped offsets return zero.
  always_comb
  begin
    nxt_ack = reg_req;
    nxt_err = reg_req && (!hit_any || wr_refused);
    nxt_rdata = 32'h0000_0000;
    if (reg_req && !reg_wr)
    begin
      case (1'b1)
        hit_feature: nxt_rdata = feature_word;
        hit_port: nxt_rdata = port_word;
        hit_source: nxt_rdata = source_word;
        hit_dest: nxt_rdata = dest_word;
        hit_info: nxt_rdata = stream_info_word;
        hit_stream_ctl: nxt_rdata = stream_ctl_word;
        hit_addr_ctl: nxt_rdata = addr_ctl_word;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Answer: registers
  // ----------------------------------------------------------------
  // Read data holds until the next read so a slow master can sample it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_ack_ff <= 1'b0;
      reg_err_ff <= 1'b0;
      reg_rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      reg_ack_ff <= nxt_ack;
      reg_err_ff <= nxt_err;
      if (reg_req && !reg_wr)
      begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the logical layer
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_ack = reg_ack_ff;
    reg_err = reg_err_ff;
    reg_rdata = reg_rdata_ff;
    // Source and destination ID generation follows the feature bit
    large_id_mode = LARGE_SYS;
    addr_width_sel = addr_width_sel_ff;
    traffic_mgmt_select = traffic_mgmt_select_ff;
    // Only the disabled mode is implemented; flag anything else
    traffic_mgmt_unsupported = (traffic_mgmt_select_ff != RST_TM_SELECT);
    // Code is block size over four, so bytes are code times four
    seg_payload_bytes = {seg_payload_size_ff[6:0], 2'b00};
  end

endmodule // rcb_csr_bank

// ==== rtl/rcb_pkg.sv ====
// Constants shared by the capability register bank of a serial endpoint.
// Assumes a single core clock and byte offsets on an 8-bit register port.
package rcb_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ELEMENT_FEATURE_FLAGS = 8'h10;
  localparam logic [7:0] OFS_SWITCH_PORT_INFO = 8'h14;
  localparam logic [7:0] OFS_SOURCE_OPERATION_CAPS = 8'h18;
  localparam logic [7:0] OFS_DESTINATION_OPERATION_CAPS = 8'h1C;
  localparam logic [7:0] OFS_STREAMING_CAPABILITY_INFO = 8'h3C;
  localparam logic [7:0] OFS_STREAMING_LOGICAL_CONTROL = 8'h48;
  localparam logic [7:0] OFS_LOGICAL_LAYER_ADDRESS_CONTROL = 8'h4C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FEAT_LARGE_SYS_BIT = 4;
  localparam int FEAT_EXT_FEAT_BIT = 3;
  localparam int FEAT_EXT_ADDR_LSB = 0;
  localparam int PORT_TOTAL_LSB = 8;
  localparam int PORT_NUM_LSB = 0;
  localparam int OP_STREAM_TM_BIT = 19;
  localparam int OP_STREAM_BIT = 18;
  localparam int OP_PORT_WRITE_BIT = 2;
  localparam int INFO_MAX_UNIT_LSB = 16;
  localparam int INFO_SEG_CTX_LSB = 0;
  localparam int CTL_TM_TYPES_LSB = 28;
  localparam int CTL_TM_SELECT_LSB = 24;
  localparam int CTL_SEG_PAYLOAD_LSB = 0;
  localparam int CTL_ADDR_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_LARGE_SYS = 1'b0;
  localparam logic RST_EXT_FEAT = 1'b1;
  localparam logic [2:0] RST_EXT_ADDR_SUPPORT = 3'h1;
  localparam logic [7:0] RST_PORT_TOTAL = 8'h04;
  localparam logic RST_STREAM_TM = 1'b0;
  localparam logic [15:0] RST_MAX_UNIT_SIZE = 16'h0000;
  localparam logic [15:0] RST_SEG_CONTEXT_COUNT = 16'h0010;
  localparam logic [3:0] RST_TM_TYPE_CAPS = 4'h0;
  localparam logic [3:0] RST_TM_SELECT = 4'h0;
  localparam logic [7:0] RST_SEG_PAYLOAD_SIZE = 8'h40;
  localparam logic [2:0] RST_ADDR_SEL = 3'h1;

  // ----------------------------------------------------------------
  // Encodings and limits
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_SEL_34 = 3'h1;
  localparam logic [2:0] ADDR_SEL_50 = 3'h2;
  localparam logic [2:0] ADDR_SEL_66 = 3'h4;
  localparam logic [7:0] SEG_PAYLOAD_MIN = 8'h04;
  localparam logic [7:0] SEG_PAYLOAD_MAX = 8'h40;

  // Segment payload code is block size over four, 16-byte steps
  function automatic logic seg_payload_ok(input logic [7:0] code);
    seg_payload_ok = (code >= SEG_PAYLOAD_MIN) && (code <= SEG_PAYLOAD_MAX) &&
                     (code[1:0] == 2'h0);
  endfunction

  // Address select must be one-hot and among the supported widths
  function automatic logic addr_sel_ok(input logic [2:0] code, input logic [2:0] support);
    logic ok;
    ok = 1'b0;
    case (code)
      ADDR_SEL_34: ok = support[0];
      ADDR_SEL_50: ok = support[1];
      ADDR_SEL_66: ok = support[2];
      default: ok = 1'b0;
    endcase
    addr_sel_ok = ok;
  endfunction

endpackage : rcb_pkg

// ==== rtl/rcb_wfield.sv ====
// Writable register field with a write filter.
// Assumes the caller decodes the write and judges the value legal.
`timescale 1ns/1ps
module rcb_wfield #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic wr_legal,
  input wire logic [WIDTH-1:0] wr_val,
  output logic [WIDTH-1:0] field_ff
);
  import rcb_pkg::*;

  logic [WIDTH-1:0] nxt_field; // Next field value

  // ----------------------------------------------------------------
  // Next value: illegal codes leave the old value in place
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_field = field_ff;
    if (wr_en && wr_legal)
    begin
      nxt_field = wr_val;
    end
  end

  // Field storage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      field_ff <= RESET_VAL;
    end
    else
    begin
      field_ff <= nxt_field;
    end
  end
endmodule // rcb_wfield

// ==== rtl/rcb_cap_words.sv ====
// Fixed capability words of the bank, built from parameters.
// Assumes the parameters have been range-checked by the caller.
`timescale 1ns/1ps
module rcb_cap_words #(
  parameter logic LARGE_SYS = 1'b0,
  parameter logic [2:0] EXT_ADDR_SUPPORT = 3'h1,
  parameter logic [7:0] PORT_TOTAL = 8'h04,
  parameter logic [15:0] MAX_UNIT_SIZE = 16'h0000,
  parameter logic [15:0] SEG_CONTEXT_COUNT = 16'h0010
) (
  output logic [31:0] feature_word,
  output logic [31:0] source_word,
  output logic [31:0] dest_word,
  output logic [31:0] stream_info_word
);
  import rcb_pkg::*;

  // ----------------------------------------------------------------
  // Constant words; no storage, writes can never reach them
  // ----------------------------------------------------------------
  always_comb
  begin
    feature_word = 32'h0000_0000;
    feature_word[FEAT_LARGE_SYS_BIT] = LARGE_SYS;
    feature_word[FEAT_EXT_FEAT_BIT] = RST_EXT_FEAT;
    feature_word[FEAT_EXT_ADDR_LSB +: 3] = EXT_ADDR_SUPPORT;
    // Source: streaming and port-write generation only
    source_word = 32'h0000_0000;
    source_word[OP_STREAM_BIT] = 1'b1;
    source_word[OP_STREAM_TM_BIT] = RST_STREAM_TM;
    source_word[OP_PORT_WRITE_BIT] = 1'b1;
    // Destination: port-write only
    dest_word = 32'h0000_0000;
    dest_word[OP_PORT_WRITE_BIT] = 1'b1;
    stream_info_word = 32'h0000_0000;
    stream_info_word[INFO_MAX_UNIT_LSB +: 16] = MAX_UNIT_SIZE;
    stream_info_word[INFO_SEG_CTX_LSB +: 16] = SEG_CONTEXT_COUNT;
  end
endmodule // rcb_cap_words

// ==== verif/rcb_csr_bank_asserts.sv ====
// Concurrent checks on the capability register bank ports.
// Assumes binding to rcb_csr_bank; sees only its ports.
`timescale 1ns/1ps
module rcb_csr_bank_asserts
  import rcb_pkg::*;
#(
  parameter logic LARGE_SYS = 1'b0,
  parameter logic [2:0] EXT_ADDR_SUPPORT = 3'h1,
  parameter logic [7:0] PORT_TOTAL = 8'h04
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_from_link,
  input wire logic [7:0] reg_link_port,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [31:0] reg_rdata,
  input wire logic large_id_mode,
  input wire logic [2:0] addr_width_sel,
  input wire logic [3:0] traffic_mgmt_select,
  input wire logic traffic_mgmt_unsupported,
  input wire logic [8:0] seg_payload_bytes
);
  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic rd; // Read taken this edge
  logic wr_strm; // Write to streaming control
  logic wr_addr; // Write to address control
  logic pay_ok; // Payload code on the legal 16-byte grid
  logic addr_ok; // One-hot width that the element supports
  assign rd = reg_req && !reg_wr;
  assign wr_strm = reg_req && reg_wr && reg_addr == OFS_STREAMING_LOGICAL_CONTROL;
  assign wr_addr = reg_req && reg_wr && reg_addr == OFS_LOGICAL_LAYER_ADDRESS_CONTROL;
  assign pay_ok = reg_wdata[7:0] >= 8'h04 && reg_wdata[7:0] <= 8'h40 && reg_wdata[1:0] == 2'h0;
  assign addr_ok = $onehot(reg_wdata[2:0]) && |(reg_wdata[2:0] & EXT_ADDR_SUPPORT);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ack_one_cycle: assert property (1'b1 |=> reg_ack == $past(reg_req))
    else $error("answer strobe not one cycle after request");
  a_feature_image: assert property (rd && reg_addr == OFS_ELEMENT_FEATURE_FLAGS |=>
    reg_rdata == {27'h0, LARGE_SYS, 1'b1, EXT_ADDR_SUPPORT}) else $error("feature image wrong");
  a_port_image: assert property (rd && reg_addr == OFS_SWITCH_PORT_INFO |=>
    reg_rdata == {16'h0, PORT_TOTAL, $past(reg_from_link) ? $past(reg_link_port) : 8'h00})
    else $error("port info image wrong");
  a_src_caps: assert property (rd && reg_addr == OFS_SOURCE_OPERATION_CAPS |=>
    reg_rdata == 32'h0004_0004) else $error("source caps wrong");
  a_dest_caps: assert property (rd && reg_addr == OFS_DESTINATION_OPERATION_CAPS |=>
    reg_rdata == 32'h0000_0004) else $error("destination caps wrong");
  a_ctl_reserved: assert property (rd && reg_addr == OFS_STREAMING_LOGICAL_CONTROL |=>
    reg_rdata[31:28] == 4'h0 && reg_rdata[23:8] == 16'h0) else $error("stream ctl reserved set");
  a_addr_upper: assert property (rd && reg_addr == OFS_LOGICAL_LAYER_ADDRESS_CONTROL |=>
    reg_rdata == {29'h0, addr_width_sel}) else $error("address control image wrong");
  a_pay_refuse: assert property (wr_strm && !pay_ok |=> reg_err &&
    $stable(seg_payload_bytes) && $stable(traffic_mgmt_select)) else $error("bad payload kept");
  a_pay_accept: assert property (wr_strm && pay_ok |=> !reg_err &&
    seg_payload_bytes == {$past(reg_wdata[6:0]), 2'b00} &&
    traffic_mgmt_select == $past(reg_wdata[27:24])) else $error("payload write lost");
  a_tm_flag: assert property (traffic_mgmt_unsupported == (traffic_mgmt_select != 4'h0))
    else $error("unsupported flag disagrees");
  a_addr_refuse: assert property (wr_addr && !addr_ok |=> reg_err &&
    $stable(addr_width_sel)) else $error("reserved width stored");
  a_addr_legal: assert property ($onehot(addr_width_sel) &&
    |(addr_width_sel & EXT_ADDR_SUPPORT)) else $error("width select illegal");
  a_large_id: assert property (large_id_mode == LARGE_SYS)
    else $error("large id mode wrong");
  a_ro_write: assert property (reg_req && reg_wr && reg_addr inside {8'h10, 8'h14, 8'h18,
    8'h1C, 8'h3C} |=> reg_ack && !reg_err) else $error("read-only write flagged");
endmodule // rcb_csr_bank_asserts

bind rcb_csr_bank rcb_csr_bank_asserts #(.LARGE_SYS(LARGE_SYS),
  .EXT_ADDR_SUPPORT(EXT_ADDR_SUPPORT), .PORT_TOTAL(PORT_TOTAL)) u_chk (.core_clk(core_clk),
  .rst_b(rst_b), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_from_link(reg_from_link), .reg_link_port(reg_link_port),
  .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata), .large_id_mode(large_id_mode),
  .addr_width_sel(addr_width_sel), .traffic_mgmt_select(traffic_mgmt_select),
  .traffic_mgmt_unsupported(traffic_mgmt_unsupported), .seg_payload_bytes(seg_payload_bytes));

// ==== verif/rcb_host_model.sv ====
// Far-side requester: remote maintenance host and local bus master.
// Assumes core_clk timing; one request per call, answer one cycle on.
`timescale 1ns/1ps
module rcb_host_model (
  input wire logic core_clk,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [31:0] reg_rdata,
  output logic reg_req,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_from_link,
  output logic [7:0] reg_link_port
);
  // Idle at time zero
  initial
  begin
    reg_req = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_from_link = 1'b0;
    reg_link_port = 8'h00;
  end

  // ----------------------------------------------------------------
  // One access; qualifiers go inverted once released so stale
  // values can never pass for a held request
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
    input logic link, input logic [7:0] port, output logic [31:0] rdata,
    output logic err, output logic ack);
    @(posedge core_clk);
    #1;
    reg_req = 1'b1;
    reg_wr = wr;
    reg_addr = addr;
    reg_wdata = wdata;
    reg_from_link = link; // Local master reads port zero
    reg_link_port = port;
    @(posedge core_clk);
    #1;
    // Taken at that edge; ack and error stand for one cycle only, read data until the next read
    ack = reg_ack;
    err = reg_err;
    rdata = reg_rdata;
    reg_req = 1'b0;
    reg_wr = ~wr;
    reg_addr = ~addr;
    reg_wdata = ~wdata;
    reg_from_link = ~link;
    reg_link_port = ~port;
  endtask
endmodule // rcb_host_model

// ==== verif/rapidio_capability_csr_bank_tb_top.sv ====
// Self-checking bench for the capability register bank.
// Assumes default parameters; the host model issues every request.
`timescale 1ns/1ps
module rapidio_capability_csr_bank_tb_top;
  import rcb_pkg::*;
  logic core_clk;
  logic rst_b;
  logic reg_req, reg_wr, reg_from_link, reg_ack, reg_err, large_id_mode, traffic_mgmt_unsupported;
  logic [7:0] reg_addr, reg_link_port;
  logic [31:0] reg_wdata, reg_rdata, rdata_s;
  logic [2:0] addr_width_sel;
  logic [3:0] traffic_mgmt_select;
  logic [8:0] seg_payload_bytes;
  logic err_s, ack_s;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  // Register offsets and their reset images
  logic [7:0] ofs [7] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h3C, 8'h48, 8'h4C};
  logic [31:0] img [7] = '{32'h9, 32'h400, 32'h0004_0004, 32'h4, 32'h10, 32'h40, 32'h1};

  rcb_csr_bank DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_from_link(reg_from_link),
    .reg_link_port(reg_link_port), .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata),
    .large_id_mode(large_id_mode), .addr_width_sel(addr_width_sel),
    .traffic_mgmt_select(traffic_mgmt_select), .traffic_mgmt_unsupported(traffic_mgmt_unsupported),
    .seg_payload_bytes(seg_payload_bytes));
  rcb_host_model u_host (.core_clk(core_clk), .reg_ack(reg_ack), .reg_err(reg_err),
    .reg_rdata(reg_rdata), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_from_link(reg_from_link), .reg_link_port(reg_link_port));

  // ----------------------------------------------------------------
  // Clock, and a hang limit well above the roughly 190 cycles used
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Every access must be answered
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic link, input logic [7:0] p);
    u_host.access(wr, a, d, link, p, rdata_s, err_s, ack_s);
    check({31'h0, ack_s}, 32'h1);
  endtask

  task automatic t_reset_images();
    foreach (ofs[i])
    begin
      xfer(1'b0, ofs[i], 32'h0, 1'b0, 8'h00);
      check(rdata_s, img[i]);
    end
    // Unmapped and misaligned offsets answer with an error and zero
    foreach (img[i])
    begin
      xfer(1'b0, 8'h11 + 8'(i * 9), 32'h0, 1'b1, 8'h03);
      check({err_s, rdata_s[30:0]}, 32'h8000_0000);
    end
    check({large_id_mode, addr_width_sel}, 32'h1);
    check({traffic_mgmt_unsupported, traffic_mgmt_select, seg_payload_bytes}, 32'h100);
  endtask

  // Writes of all ones to read-only words leave them untouched
  task automatic t_ro_writes();
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, ofs[i], 32'hFFFF_FFFF, 1'b1, 8'h01);
      check({31'h0, err_s}, 32'h0);
      xfer(1'b0, ofs[i], 32'h0, 1'b0, 8'h00);
      check(rdata_s, img[i]);
    end
  endtask

  // Port number follows the arrival port; local reads see zero
  task automatic t_port_num();
    logic [7:0] p [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    foreach (p[i])
    begin
      xfer(1'b0, 8'h14, 32'h0, 1'b1, p[i]);
      check(rdata_s, {16'h0, 8'h04, p[i]});
      xfer(1'b0, 8'h14, 32'h0, 1'b0, p[i]);
      check(rdata_s, 32'h400);
    end
  endtask

  // Every legal payload code, every traffic mode, then refused codes
  task automatic t_stream_ctl();
    logic [7:0] bad [5] = '{8'h00, 8'h03, 8'h06, 8'h44, 8'hFF};
    logic [3:0] tm;
    for (int c = 4; c <= 64; c += 4)
    begin
      tm = 4'(c / 4);
      xfer(1'b1, 8'h48, {4'hF, tm, 16'hFFFF, 8'(c)}, 1'b0, 8'h00);
      check({31'h0, err_s}, 32'h0);
      check({23'h0, seg_payload_bytes}, 32'(c * 4));
      check({traffic_mgmt_unsupported, traffic_mgmt_select}, {27'h0, tm != 4'h0, tm});
      xfer(1'b0, 8'h48, 32'h0, 1'b1, 8'h02);
      check(rdata_s, {4'h0, tm, 16'h0, 8'(c)});
    end
    foreach (bad[i])
    begin
      xfer(1'b1, 8'h48, {8'h02, 16'h0, bad[i]}, 1'b1, 8'h00);
      check({err_s, traffic_mgmt_select, seg_payload_bytes}, 32'h2100);
    end
  endtask

  // All eight width codes; only the 34-bit one is supported here
  task automatic t_addr_ctl();
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, 8'h4C, {29'h1FFF_FFFF, 3'(c)}, 1'b0, 8'h00);
      check({31'h0, err_s}, {31'h0, c != 1});
      check({29'h0, addr_width_sel}, 32'h1);
      xfer(1'b0, 8'h4C, 32'h0, 1'b0, 8'h00);
      check(rdata_s, 32'h1);
    end
  endtask

  // A second reset in mid-run restores the writable fields
  task automatic t_rereset();
    xfer(1'b1, 8'h48, 32'h0300_0008, 1'b0, 8'h00);
    check({28'h0, traffic_mgmt_select}, 32'h3);
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    check({traffic_mgmt_unsupported, traffic_mgmt_select, seg_payload_bytes}, 32'h100);
    xfer(1'b0, 8'h48, 32'h0, 1'b0, 8'h00);
    check(rdata_s, 32'h40);
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_reset_images();
    t_ro_writes();
    t_port_num();
    t_stream_ctl();
    t_addr_ctl();
    t_rereset();
    finish_test();
  end
endmodule // rapidio_capability_csr_bank_tb_top
